// [rtl/sbocd_pkg.sv]
package sbocd_pkg;

  // ---------------------------------------------------------------
  // word format
  // ---------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 11;
  localparam int OP_W    = 5;
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 11;
  localparam int SIGN_B  = 15;
  localparam int MEM_DEPTH = 2048;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 11'h001;

  // ---------------------------------------------------------------
  // operation codes (the rest of the 32 act as no-ops)
  // ---------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_HALT  = 5'h00,
    OP_CLEAR_ADD = 5'h01,
    OP_ADD   = 5'h02,
    OP_SUB   = 5'h03,
    OP_CLEAR_SUB = 5'h04,
    OP_STORE = 5'h05,
    OP_OUTPUT = 5'h06,
    OP_INPUT = 5'h07,
    OP_JUMP  = 5'h08,
    OP_JUMP_NEG = 5'h09
  } sbocd_op_t;

  // ---------------------------------------------------------------
  // bus sources: at most one may drive per cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_NONE    = 3'h0,
    SRC_STORAGE = 3'h1,
    SRC_CONTROL = 3'h2,
    SRC_ARITH   = 3'h3,
    SRC_INPUT   = 3'h4
  } sbocd_src_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC  = 2'h2
  } sbocd_state_t;

  // negation is plain bit inversion, no increment
  function automatic logic [WORD_W-1:0] ones_negate(input logic [WORD_W-1:0] w);
    ones_negate = ~w;
  endfunction

endpackage

// [rtl/sbocd_adder.sv]
`timescale 1ns/1ps
`default_nettype none

module sbocd_adder
  import sbocd_pkg::*;
(
  // operands
  input  wire logic [WORD_W-1:0] a,
  input  wire logic [WORD_W-1:0] b,
  input  wire logic              complement_b,
  // result
  output logic      [WORD_W-1:0] sum
);

  logic [WORD_W-1:0] b_eff;
  logic [WORD_W:0]   raw;

  always_comb begin
    // subtraction needs no subtractor, only the complementer
    b_eff = complement_b ? ones_negate(b) : b;
    raw   = {1'b0, a} + {1'b0, b_eff};
    // end-around carry keeps the ones' complement sum exact
    sum   = raw[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, raw[WORD_W]};
  end

endmodule

`default_nettype wire

// [rtl/sbocd_datapath.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - all words held as two-state binary digits
// - fixed point, no scale factor kept
// - negation inverts every bit, no increment
// - subtract by adding the complemented subtrahend
// - bus carries sixteen bits in parallel
// - one bus, units only attach or detach
// - exactly one word per transfer, sequential
// - storage, control, arithmetic, input, output attach
// - parallel registers, one element per bit
// - instruction is 5-bit opcode, 11-bit address
module sbocd_datapath
  import sbocd_pkg::*;
(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              SYS_RST,
  // run control
  input  wire logic              START,
  input  wire logic [ADDR_W-1:0] START_ADDR,
  // program load while idle, through the input unit
  input  wire logic              LOAD_VALID,
  input  wire logic [ADDR_W-1:0] LOAD_ADDR,
  // input unit
  input  wire logic              INPUT_VALID,
  input  wire logic [WORD_W-1:0] INPUT_WORD,
  output logic                   INPUT_TAKEN,
  // output unit
  output logic      [WORD_W-1:0] OUTPUT_WORD,
  output logic                   OUTPUT_STROBE,
  // observation
  output logic      [WORD_W-1:0] BUS_WORD,
  output logic      [2:0]        BUS_SOURCE,
  output logic      [WORD_W-1:0] ACC_WORD,
  output logic      [ADDR_W-1:0] PC_WORD,
  output logic                   RUNNING
);

  // ---------------------------------------------------------------
  // storage unit
  // ---------------------------------------------------------------
  // one flip-flop per bit, whole word read and written at once
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_we;
  logic [WORD_W-1:0] mem_rd;

  // ---------------------------------------------------------------
  // control and arithmetic state
  // ---------------------------------------------------------------
  sbocd_state_t      state, next_state;
  logic [ADDR_W-1:0] pc, next_pc;
  logic [WORD_W-1:0] ir, next_ir;
  logic [WORD_W-1:0] acc, next_acc;
  logic [WORD_W-1:0] out_word, next_out_word;
  logic              out_strobe, next_out_strobe;
  logic              in_taken, next_in_taken;
  logic              running, next_running;
  logic [WORD_W-1:0] bus_reg, next_bus_reg;
  sbocd_src_t        src_reg, next_src_reg;

  // ---------------------------------------------------------------
  // bus and arithmetic element
  // ---------------------------------------------------------------
  sbocd_src_t        bus_src;
  logic [WORD_W-1:0] bus;
  logic              add_sub;
  logic [WORD_W-1:0] add_sum;
  sbocd_op_t         op;
  logic [ADDR_W-1:0] ir_addr;

  // instruction fields: opcode on top, register number below
  assign op      = sbocd_op_t'(ir[OP_MSB:OP_LSB]);
  assign ir_addr = ir[ADDR_W-1:0];
  assign mem_rd  = mem[mem_addr];

  // one source mux: a unit either drives the single bus or is detached
  always_comb begin
    unique case (bus_src)
      SRC_STORAGE: bus = mem_rd;
      SRC_CONTROL: bus = {{(WORD_W-ADDR_W){1'b0}}, pc};
      SRC_ARITH:   bus = acc;
      SRC_INPUT:   bus = INPUT_WORD;
      SRC_NONE:    bus = WORD_ZERO;
      default:     bus = WORD_ZERO;
    endcase
  end

  // acc plus bus word, or acc plus its complement for subtraction
  sbocd_adder u_adder (
    .a            (acc),
    .b            (bus),
    .complement_b (add_sub),
    .sum          (add_sum)
  );

  // ---------------------------------------------------------------
  // sequencer: each state moves at most one word over the bus
  // ---------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_pc         = pc;
    next_ir         = ir;
    next_acc        = acc;
    next_out_word   = out_word;
    next_out_strobe = 1'b0;
    next_in_taken   = 1'b0;
    next_running    = running;
    bus_src         = SRC_NONE;
    mem_addr        = ir_addr;
    mem_we          = 1'b0;
    add_sub         = 1'b0;

    unique case (state)
      ST_IDLE: begin
        next_running = 1'b0;
        // start has priority; a load in the same cycle is dropped
        if (START) begin
          next_pc      = START_ADDR;
          next_running = 1'b1;
          next_state   = ST_FETCH;
        end else if (LOAD_VALID) begin
          mem_addr      = LOAD_ADDR;
          bus_src       = SRC_INPUT;
          mem_we        = 1'b1;
          next_in_taken = 1'b1;
        end
      end

      ST_FETCH: begin
        // storage to control: the order travels as an ordinary word
        mem_addr   = pc;
        bus_src    = SRC_STORAGE;
        next_ir    = bus;
        next_pc    = pc + ADDR_ONE;
        next_state = ST_EXEC;
      end

      ST_EXEC: begin
        next_state = ST_FETCH;
        case (op)
          OP_HALT: begin
            next_running = 1'b0;
            next_state   = ST_IDLE;
          end
          OP_CLEAR_ADD: begin
            bus_src  = SRC_STORAGE;
            next_acc = bus;
          end
          OP_ADD: begin
            bus_src  = SRC_STORAGE;
            next_acc = add_sum;
          end
          OP_SUB: begin
            bus_src  = SRC_STORAGE;
            add_sub  = 1'b1;
            next_acc = add_sum;
          end
          OP_CLEAR_SUB: begin
            bus_src  = SRC_STORAGE;
            next_acc = ones_negate(bus);
          end
          OP_STORE: begin
            bus_src = SRC_ARITH;
            mem_we  = 1'b1;
          end
          OP_OUTPUT: begin
            bus_src         = SRC_ARITH;
            next_out_word   = bus;
            next_out_strobe = 1'b1;
          end
          OP_INPUT: begin
            // holds in execute until the input unit offers a word
            if (INPUT_VALID) begin
              bus_src       = SRC_INPUT;
              mem_we        = 1'b1;
              next_in_taken = 1'b1;
            end else begin
              next_state = ST_EXEC;
            end
          end
          OP_JUMP: begin
            next_pc = ir_addr;
          end
          OP_JUMP_NEG: begin
            // sign bit set means negative, including negative zero
            if (acc[SIGN_B]) begin
              next_pc = ir_addr;
            end
          end
          default: begin
            next_state = ST_FETCH;
          end
        endcase
      end

      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // word stays binary fixed point, no scale bits anywhere
    next_bus_reg = bus;
    next_src_reg = bus_src;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state      <= ST_IDLE;
      pc         <= ADDR_ZERO;
      ir         <= WORD_ZERO;
      acc        <= WORD_ZERO;
      out_word   <= WORD_ZERO;
      out_strobe <= 1'b0;
      in_taken   <= 1'b0;
      running    <= 1'b0;
      bus_reg    <= WORD_ZERO;
      src_reg    <= SRC_NONE;
    end else begin
      state      <= next_state;
      pc         <= next_pc;
      ir         <= next_ir;
      acc        <= next_acc;
      out_word   <= next_out_word;
      out_strobe <= next_out_strobe;
      in_taken   <= next_in_taken;
      running    <= next_running;
      bus_reg    <= next_bus_reg;
      src_reg    <= next_src_reg;
    end
  end

  // storage carries no reset, so it can map to plain ram
  always_ff @(posedge CLOCK) begin
    if (mem_we) begin
      mem[mem_addr] <= bus;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign INPUT_TAKEN   = in_taken;
  assign OUTPUT_WORD   = out_word;
  assign OUTPUT_STROBE = out_strobe;
  assign BUS_WORD      = bus_reg;
  assign BUS_SOURCE    = src_reg;
  assign ACC_WORD      = acc;
  assign PC_WORD       = pc;
  assign RUNNING       = running;

endmodule

`default_nettype wire

// [tb/sbocd_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sbocd_chk
  import sbocd_pkg::*;
(
  // clock and reset
  input wire logic              CLOCK,
  input wire logic              SYS_RST,
  // requests
  input wire logic              START,
  input wire logic [ADDR_W-1:0] START_ADDR,
  input wire logic              LOAD_VALID,
  input wire logic [WORD_W-1:0] INPUT_WORD,
  // answers
  input wire logic              INPUT_TAKEN,
  input wire logic [WORD_W-1:0] OUTPUT_WORD,
  input wire logic              OUTPUT_STROBE,
  input wire logic [WORD_W-1:0] BUS_WORD,
  input wire logic [2:0]        BUS_SOURCE,
  input wire logic [WORD_W-1:0] ACC_WORD,
  input wire logic [ADDR_W-1:0] PC_WORD,
  input wire logic              RUNNING
);
  // ----
  // properties
  // ----
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic idle_load;
  assign idle_load = !RUNNING && !START && LOAD_VALID;
  a_load_taken: assert property (idle_load |=> INPUT_TAKEN && BUS_SOURCE == 3'h4
    && BUS_WORD == $past(INPUT_WORD)) else $error("load word not taken");
  a_start_run: assert property (!RUNNING && START |=> RUNNING
    && PC_WORD == $past(START_ADDR)) else $error("run did not start");
  a_idle_quiet: assert property (!RUNNING && !START && !LOAD_VALID
    |=> BUS_SOURCE == 3'h0) else $error("bus driven while idle");
  a_no_source: assert property (BUS_SOURCE == 3'h0 |-> BUS_WORD == 16'h0000)
    else $error("bus word without source");
  a_src_legal: assert property (BUS_SOURCE <= 3'h4)
    else $error("unknown bus source");
  a_out_acc: assert property (OUTPUT_STROBE |-> BUS_SOURCE == 3'h3
    && BUS_WORD == ACC_WORD && OUTPUT_WORD == ACC_WORD) else $error("output not acc");
  a_out_pulse: assert property (OUTPUT_STROBE |=> !OUTPUT_STROBE)
    else $error("output strobe too long");
  a_idle_hold: assert property (!RUNNING && !START |=> $stable(ACC_WORD)
    && $stable(PC_WORD)) else $error("state moved while idle");
  c_load: cover property (idle_load);
  c_out: cover property (OUTPUT_STROBE);
  c_halt: cover property ($fell(RUNNING));
endmodule
bind sbocd_datapath sbocd_chk sbocd_chk_inst (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .START(START), .START_ADDR(START_ADDR),
  .LOAD_VALID(LOAD_VALID), .INPUT_WORD(INPUT_WORD), .INPUT_TAKEN(INPUT_TAKEN),
  .OUTPUT_WORD(OUTPUT_WORD), .OUTPUT_STROBE(OUTPUT_STROBE), .BUS_WORD(BUS_WORD),
  .BUS_SOURCE(BUS_SOURCE), .ACC_WORD(ACC_WORD), .PC_WORD(PC_WORD), .RUNNING(RUNNING)
);
`default_nettype wire

// [tb/sbocd_io_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sbocd_io_model
  import sbocd_pkg::*;
#(
  parameter int                DELAY = 3,
  parameter logic [WORD_W-1:0] OFFER = 16'h1234
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // design side
  input  wire logic              running,
  input  wire logic              input_taken,
  input  wire logic [WORD_W-1:0] output_word,
  input  wire logic              output_strobe,
  // bench side, used while idle
  input  wire logic [WORD_W-1:0] load_word,
  output logic                   input_valid,
  output logic      [WORD_W-1:0] input_word
);
  logic [WORD_W-1:0] got [$];
  int                wait_cnt;
  logic              served;
  // the inverse pattern keeps a stale word from passing as a fresh one
  assign input_word = !running ? load_word : (input_valid ? OFFER : ~OFFER);
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= 0;
      served <= 1'b0;
      input_valid <= 1'b0;
    end else begin
      if (output_strobe)
        got.push_back(output_word);
      if (!running) begin
        wait_cnt <= 0;
        served <= 1'b0;
        input_valid <= 1'b0;
      end else if (input_taken) begin
        served <= 1'b1;
        input_valid <= 1'b0;
      end else if (!served) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == DELAY)
          input_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/single_bus_ones_complement_datapath_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, ac); end end
module single_bus_ones_complement_datapath_tb
  import sbocd_pkg::*;
;
  logic              CLOCK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic              START = 1'b0;
  logic              LOAD_VALID = 1'b0;
  logic [ADDR_W-1:0] START_ADDR = 11'h000;
  logic [ADDR_W-1:0] LOAD_ADDR = 11'h000;
  logic [WORD_W-1:0] load_word = 16'h0000;
  logic              INPUT_VALID, INPUT_TAKEN, OUTPUT_STROBE, RUNNING;
  logic [WORD_W-1:0] INPUT_WORD, OUTPUT_WORD, BUS_WORD, ACC_WORD;
  logic [2:0]        BUS_SOURCE;
  logic [ADDR_W-1:0] PC_WORD;
  int                failures = 0;
  int                checks = 0;
  int                cycles = 0;
  // ----
  // program: add with wrap carry, subtract, negate, input, jumps, store
  // ----
  localparam logic [WORD_W-1:0] PROG [0:20] = '{16'h0820, 16'h1021, 16'h3000,
    16'h1821, 16'h3000, 16'h2021, 16'h3000, 16'h3822, 16'h0822, 16'h480B, 16'h2022,
    16'h480D, 16'h3000, 16'h2823, 16'h4010, 16'h3000, 16'h0823, 16'h3000, 16'h0000,
    16'hFFFE, 16'h0003};
  sbocd_datapath sbocd_datapath_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .START(START),
    .START_ADDR(START_ADDR), .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR),
    .INPUT_VALID(INPUT_VALID), .INPUT_WORD(INPUT_WORD), .INPUT_TAKEN(INPUT_TAKEN),
    .OUTPUT_WORD(OUTPUT_WORD), .OUTPUT_STROBE(OUTPUT_STROBE), .BUS_WORD(BUS_WORD),
    .BUS_SOURCE(BUS_SOURCE), .ACC_WORD(ACC_WORD), .PC_WORD(PC_WORD), .RUNNING(RUNNING));
  // slow input unit, so the input order has to stall
  sbocd_io_model #(.DELAY(20)) sbocd_io_model_inst (.clock(CLOCK), .sys_rst(SYS_RST),
    .running(RUNNING), .input_taken(INPUT_TAKEN), .output_word(OUTPUT_WORD),
    .output_strobe(OUTPUT_STROBE), .load_word(load_word), .input_valid(INPUT_VALID),
    .input_word(INPUT_WORD));
  initial begin
    forever #2.5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  task give_verdict;
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // back-to-back loads; data words go to 020h and 021h
  task load_program;
    for (int i = 0; i <= 20; i++) begin
      @(posedge CLOCK);
      LOAD_VALID <= 1'b1;
      LOAD_ADDR <= (i < 19) ? 11'(i) : 11'(i + 13);
      load_word <= PROG[i];
      @(negedge CLOCK);
      if (i > 0)
        `CHECK("load bus", PROG[i-1], BUS_WORD)
    end
    @(posedge CLOCK);
    LOAD_VALID <= 1'b0;
    @(negedge CLOCK);
    `CHECK("load taken", 1'b1, INPUT_TAKEN)
    @(negedge CLOCK);
    `CHECK("taken drop", 1'b0, INPUT_TAKEN)
  endtask
  // start and load held on while running must both be ignored
  task run_program;
    int n;
    @(posedge CLOCK);
    START <= 1'b1;
    @(posedge CLOCK);
    START_ADDR <= 11'h00F;
    LOAD_ADDR <= 11'h021;
    LOAD_VALID <= 1'b1;
    repeat (20) @(posedge CLOCK);
    START <= 1'b0;
    LOAD_VALID <= 1'b0;
    n = 0;
    while (RUNNING !== 1'b0 && n < 500) begin
      @(negedge CLOCK);
      n++;
    end
    `CHECK("halted", 1'b0, RUNNING)
    `CHECK("outputs", 4, sbocd_io_model_inst.got.size())
    `CHECK("wrap add", 16'h0002, sbocd_io_model_inst.got[0])
    `CHECK("subtract", 16'hFFFE, sbocd_io_model_inst.got[1])
    `CHECK("negate", 16'hFFFC, sbocd_io_model_inst.got[2])
    `CHECK("stored", 16'hEDCB, sbocd_io_model_inst.got[3])
    `CHECK("acc", 16'hEDCB, ACC_WORD)
    `CHECK("pc", 11'h013, PC_WORD)
  endtask
  // x minus x gives negative zero; a spare opcode passes; the sign jump must be taken
  localparam logic [WORD_W-1:0] EDGE_PROG [0:7] = '{16'h0850, 16'h1850, 16'h5000,
    16'h4845, 16'h0000, 16'h3000, 16'h0000, 16'h00F0};
  task run_edge_cases;
    int n;
    for (int i = 0; i <= 7; i++) begin
      @(posedge CLOCK);
      LOAD_VALID <= 1'b1;
      LOAD_ADDR <= (i < 7) ? 11'(i + 64) : 11'h050;
      load_word <= EDGE_PROG[i];
    end
    @(posedge CLOCK);
    LOAD_VALID <= 1'b0;
    START_ADDR <= 11'h040;
    START <= 1'b1;
    @(posedge CLOCK);
    START <= 1'b0;
    @(negedge CLOCK);
    `CHECK("run started", 1'b1, RUNNING)
    n = 0;
    while (RUNNING !== 1'b0 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
    `CHECK("edge halted", 1'b0, RUNNING)
    `CHECK("edge outputs", 5, sbocd_io_model_inst.got.size())
    `CHECK("negative zero", 16'hFFFF, sbocd_io_model_inst.got[4])
    `CHECK("edge acc", 16'hFFFF, ACC_WORD)
    `CHECK("edge pc", 11'h047, PC_WORD)
  endtask
  // reset in mid-run must drop the control back to idle with cleared state
  task reset_mid_run;
    @(posedge CLOCK);
    START <= 1'b1;
    @(posedge CLOCK);
    START <= 1'b0;
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b1;
    @(negedge CLOCK);
    `CHECK("reset run", 1'b0, RUNNING)
    `CHECK("reset acc", 16'h0000, ACC_WORD)
    `CHECK("reset pc", 11'h000, PC_WORD)
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    repeat (2) @(negedge CLOCK);
    `CHECK("idle bus", 3'h0, BUS_SOURCE)
    `CHECK("idle run", 1'b0, RUNNING)
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    load_program();
    run_program();
    run_edge_cases();
    reset_mid_run();
    give_verdict();
  end
endmodule
`default_nettype wire
